/* hw/ebm_pkg.sv */
/*
  Constants, types and mode encodings shared by the external bus
  multiplexer and pin-role controller.
  Assumes one 20 MHz core clock and a synchronous, active-high reset.

  // How it works
  // - byte width: D0-D7 share A0-A7 pins
  // - word width: D0-D7 share A1-A8, upper separate
  // - address latch strobe output on fixed pin
  // - separate bus after reset; no whole-space in microprocessor
  // - whole-space multiplexing frees upper address pins
  // - select 01/10 multiplexes region one or two
  // - select 00 all separate, 11 all multiplexed
  // - shared pins are plain address when separate
  // - port-select 0 drives top four address lines
  // - expansion modes drive the bus control pins
  // - twenty address lines cover one megabyte
  // - width pin high: 8 lines, low: 16 lines
  // - bus pins only in expansion; wait everywhere
  // - address undefined until first external access
*/
package ebm_pkg;
  localparam int ADDR_W = 20;                      // one megabyte of external space
  localparam int DATA_W = 16;                      // widest external data bus

  // processor mode encodings
  localparam logic [1:0] MODE_SINGLE = 2'h0;       // internal memory only
  localparam logic [1:0] MODE_EXPAND = 2'h1;       // internal plus external memory
  localparam logic [1:0] MODE_MICRO  = 2'h3;       // external memory replaces internal rom

  // multiplexed-space select field values
  localparam logic [1:0] MUX_NONE = 2'h0;          // every region on the separate bus
  localparam logic [1:0] MUX_REG1 = 2'h1;          // region one multiplexed
  localparam logic [1:0] MUX_REG2 = 2'h2;          // region two multiplexed
  localparam logic [1:0] MUX_ALL  = 2'h3;          // whole external space multiplexed

  localparam int         MUX_FIELD_LSB = 4;        // field position in the mode byte
  localparam logic [7:0] PMODE_RST     = 8'h00;    // mode byte value held in reset
  localparam logic       BYTE_LVL_RST  = 1'h1;     // width pin assumed high in reset
  localparam logic [1:0] SW_WAIT_CYC   = 2'h1;     // cycles added by the software wait

  // shared-line masks over the address pins
  localparam logic [19:0] SHARE_MASK_8  = 20'h0_00ff;
  localparam logic [19:0] SHARE_MASK_16 = 20'h0_01fe;

  // mode control byte as the pins deliver it
  typedef struct packed {
    logic       spare7;                            // unused here
    logic       top_port_io;                       // 1: top four address pins stay ports
    logic [1:0] mux_sel;                           // multiplexed-space select field
    logic       spare3;                            // unused here
    logic       strobe_sel;                        // 1: split byte write strobes, word width only
    logic [1:0] mode;                              // processor mode
  } ebm_pmode_t;

  // one access request from the core
  typedef struct packed {
    logic [19:0] addr;                             // byte address
    logic        we;                               // 1: write
    logic [1:0]  be;                               // byte enables, bit 1 is the upper byte
    logic [15:0] wdata;                            // byte accesses use bits 7:0
    logic [1:0]  region;                           // region one / two hit from the decoder
    logic        sw_wait;                          // insert the software wait
  } ebm_req_t;

  // which pins the bus currently owns (0: general port)
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
    logic        ctrl;
  } ebm_roles_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_WAIT = 5'h04,
    ST_DATA = 5'h08,
    ST_END  = 5'h10
  } ebm_state_t;

  // whole register state of the controller
  typedef struct packed {
    ebm_state_t  st;
    ebm_req_t    rq;
    logic        mux;                              // current access is multiplexed
    logic [1:0]  wcnt;                             // software wait down-counter
    logic [15:0] rdata;
    logic        done;
    logic        bclk;
    logic [2:0]  sync;                             // width pin synchroniser
    logic        byte_lvl;                         // filtered width pin level
    ebm_pmode_t  pm;
  } ebm_core_t;
endpackage

/* hw/ebm_ctrl.sv */
/*
  External bus controller: runs one access at a time, places address
  and data on separate or time-multiplexed pins, and reports which
  port pins belong to the bus.
  Assumes the core holds mode bits stable during an access and that
  pad logic resolves each pin from its output enable.
*/
`timescale 1ns/100ps
`default_nettype none
module ebm_ctrl (
  input  wire logic                core_clk_i,
  input  wire logic                reset_i,
  input  wire ebm_pkg::ebm_pmode_t mode_ctrl_i,
  input  wire logic                byte_pin_i,
  input  wire logic                req_valid_i,
  input  wire ebm_pkg::ebm_req_t   req_i,
  output logic                     ready_o,
  output logic                     done_o,
  output logic [15:0]              rdata_o,
  output logic [19:0]              addr_o,
  output logic [19:0]              addr_oe_o,
  input  wire logic [8:0]          addr_i,
  output logic [15:0]              data_o,
  output logic [15:0]              data_oe_o,
  input  wire logic [15:0]         data_i,
  output logic                     latch_strobe_port_pin_o,
  output logic                     read_strobe_n_o,
  output logic                     low_byte_write_strobe_n_o,
  output logic                     high_byte_write_strobe_n_o,
  output logic                     bus_clock_o,
  output logic                     mux_cycle_o,
  output ebm_pkg::ebm_roles_t      pin_roles_o
);

  ebm_pkg::ebm_core_t cur;                         // registered state
  ebm_pkg::ebm_core_t nx;                          // next state

  logic        ext;                                // external bus allowed in this mode
  logic        whole;                              // whole-space multiplexing in force
  logic        w16;                                // sixteen-line data bus
  logic        busy;                               // access in progress
  logic        dphase;                             // data and hold phases
  logic        sel16;                              // split byte write strobes in use
  logic [19:0] share;                              // pins shared by address and data
  logic [19:0] dshift;                             // write byte placed on shared pins

  // mode decode from the registered mode byte
  assign ext    = (cur.pm.mode == ebm_pkg::MODE_EXPAND) ||
                  (cur.pm.mode == ebm_pkg::MODE_MICRO);
  // whole-space only in expansion mode; microprocessor falls back to separate
  assign whole  = (cur.pm.mux_sel == ebm_pkg::MUX_ALL) &&
                  (cur.pm.mode == ebm_pkg::MODE_EXPAND);
  assign w16    = ~cur.byte_lvl;
  assign busy   = (cur.st != ebm_pkg::ST_IDLE);
  assign dphase = (cur.st == ebm_pkg::ST_DATA) || (cur.st == ebm_pkg::ST_END);
  assign sel16  = w16 && cur.pm.strobe_sel;

  // byte width shares A0-A7; word width shares A1-A8 and leaves A0 alone
  assign share  = w16 ? ebm_pkg::SHARE_MASK_16 : ebm_pkg::SHARE_MASK_8;
  assign dshift = w16 ? {11'h000, cur.rq.wdata[7:0], 1'h0}
                      : {12'h000, cur.rq.wdata[7:0]};

  // pin ownership; single-chip mode leaves every pin to the ports
  always_comb begin
    pin_roles_o.ctrl           = ext;
    pin_roles_o.addr[8:0]      = {9{ext}};
    pin_roles_o.addr[15:9]     = {7{ext && !whole}};
    pin_roles_o.addr[19:16]    = {4{ext && !whole && !cur.pm.top_port_io}};
    pin_roles_o.data[7:0]      = {8{ext && !whole}};
    pin_roles_o.data[15:8]     = {8{ext && !whole && w16}};
  end

  // address pins: the last external address stays until the next access,
  // so after leaving single-chip mode the value means nothing until then
  always_comb begin
    addr_o    = cur.rq.addr;
    addr_oe_o = pin_roles_o.addr;
    if (cur.mux && dphase) begin
      if (cur.rq.we) begin
        addr_o = (cur.rq.addr & ~share) | (dshift & share);
      end else begin
        addr_oe_o = pin_roles_o.addr & ~share;                   // release shared lines
      end
    end
  end

  // dedicated data pins; the upper byte never rides the shared lines
  always_comb begin
    data_o          = cur.rq.wdata;
    data_oe_o[7:0]  = pin_roles_o.data[7:0] & {8{dphase && cur.rq.we && !cur.mux}};
    data_oe_o[15:8] = pin_roles_o.data[15:8] & {8{dphase && cur.rq.we}};
  end

  // bus control strobes; the strobe ends as the shared lines flip, or one phase before with the software wait
  always_comb begin
    latch_strobe_port_pin_o = ext && (cur.st == ebm_pkg::ST_ADDR);
    read_strobe_n_o         = !(ext && (cur.st == ebm_pkg::ST_DATA) && !cur.rq.we);
    // low pin carries the plain write strobe unless split strobes are chosen
    low_byte_write_strobe_n_o = !(ext && (cur.st == ebm_pkg::ST_DATA) && cur.rq.we &&
                                  (!sel16 || cur.rq.be[0]));
    // high pin is the byte-high enable for the whole access otherwise
    if (sel16) begin
      high_byte_write_strobe_n_o = !(ext && (cur.st == ebm_pkg::ST_DATA) &&
                                     cur.rq.we && cur.rq.be[1]);
    end else begin
      high_byte_write_strobe_n_o = !(ext && busy && cur.rq.be[1]);
    end
  end

  assign bus_clock_o = cur.bclk;
  assign ready_o     = !busy;
  assign done_o      = cur.done;
  assign rdata_o     = cur.rdata;
  assign mux_cycle_o = busy && cur.mux;

  // next-state logic for the whole controller
  always_comb begin
    nx      = cur;
    nx.done = 1'h0;
    nx.bclk = ~cur.bclk;                           // bus clock at half the core rate
    nx.pm   = mode_ctrl_i;
    // width pin: a change counts once stages two and three agree
    nx.sync = {cur.sync[1:0], byte_pin_i};
    if (cur.sync[1] == cur.sync[2]) begin
      nx.byte_lvl = cur.sync[2];                   // relies on a steady pin
    end
    case (cur.st)
      ebm_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          nx.rq  = req_i;
          // format is fixed per access; regions are separate unless picked
          nx.mux = ext && (whole ||
                   ((cur.pm.mux_sel == ebm_pkg::MUX_REG1) && req_i.region[0]) ||
                   ((cur.pm.mux_sel == ebm_pkg::MUX_REG2) && req_i.region[1]));
          nx.st  = ebm_pkg::ST_ADDR;
        end
      end
      ebm_pkg::ST_ADDR: begin
        // the wait is counted in every mode, even with the pins idle
        nx.wcnt = ebm_pkg::SW_WAIT_CYC;
        nx.st   = cur.rq.sw_wait ? ebm_pkg::ST_WAIT : ebm_pkg::ST_DATA;
      end
      ebm_pkg::ST_WAIT: begin
        if (cur.wcnt <= 2'h1) begin
          nx.st = ebm_pkg::ST_DATA;
        end else begin
          nx.wcnt = cur.wcnt - 2'h1;
        end
      end
      ebm_pkg::ST_DATA: begin
        if (!cur.rq.we) begin
          nx.rdata[15:8] = w16 ? data_i[15:8] : 8'h00;
          if (cur.mux) begin
            nx.rdata[7:0] = w16 ? addr_i[8:1] : addr_i[7:0];
          end else begin
            nx.rdata[7:0] = data_i[7:0];
          end
        end
        nx.st = ebm_pkg::ST_END;
      end
      ebm_pkg::ST_END: begin
        nx.done = 1'h1;
        nx.st   = ebm_pkg::ST_IDLE;
      end
      default: begin
        nx.st = ebm_pkg::ST_IDLE;                  // recover from a corrupt code
      end
    endcase
  end

  // state register; reset leaves a separate-bus configuration
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cur          <= '0;
      cur.st       <= ebm_pkg::ST_IDLE;
      cur.pm       <= ebm_pkg::PMODE_RST;
      cur.byte_lvl <= ebm_pkg::BYTE_LVL_RST;
      cur.sync     <= {3{ebm_pkg::BYTE_LVL_RST}};  // match the level, so no false width edge
    end else begin
      cur <= nx;
    end
  end

  // checks on the pin behaviour
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_addr_phase;
    cur.st == ebm_pkg::ST_ADDR;
  endsequence

  sequence s_waited_access;
    s_addr_phase ##1 (cur.st == ebm_pkg::ST_WAIT) ##1 (cur.st == ebm_pkg::ST_DATA)
      ##1 (cur.st == ebm_pkg::ST_END && !done_o) ##1 done_o;
  endsequence

  property p_strobe_window;
    latch_strobe_port_pin_o |-> s_addr_phase and ext;
  endproperty
  a_strobe_window: assert property (p_strobe_window) else $error("latch strobe off phase");

  property p_strobe_drop;
    (s_addr_phase and ext) |-> (latch_strobe_port_pin_o && read_strobe_n_o &&
      low_byte_write_strobe_n_o) ##1 !latch_strobe_port_pin_o;
  endproperty
  a_strobe_drop: assert property (p_strobe_drop) else $error("latch strobe overlaps data");

  property p_mux_byte;
    (cur.st == ebm_pkg::ST_DATA && cur.mux && !w16 && cur.rq.we) |->
      (addr_o[7:0] == cur.rq.wdata[7:0]) && (addr_oe_o[7:0] == 8'hff);
  endproperty
  a_mux_byte: assert property (p_mux_byte) else $error("byte data not on A0-A7");

  property p_mux_word;
    (cur.st == ebm_pkg::ST_DATA && cur.mux && w16 && cur.rq.we) |->
      (addr_o[8:1] == cur.rq.wdata[7:0]) && (addr_o[0] == cur.rq.addr[0]) &&
      (data_oe_o[15:8] == 8'hff) && (data_oe_o[7:0] == 8'h00);
  endproperty
  a_mux_word: assert property (p_mux_word) else $error("word mux placement wrong");

  property p_separate;
    (ext && busy && !cur.mux) |-> (addr_o == cur.rq.addr) && (addr_oe_o[8:0] == 9'h1ff);
  endproperty
  a_separate: assert property (p_separate) else $error("separate bus lost address");

  property p_after_reset;
    $past(reset_i) |-> (cur.pm.mux_sel == ebm_pkg::MUX_NONE) && ready_o && !mux_cycle_o;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("not separate after reset");

  property p_micro_whole;
    (ready_o && req_valid_i && cur.pm.mode == ebm_pkg::MODE_MICRO) |=> !cur.mux;
  endproperty
  a_micro_whole: assert property (p_micro_whole) else $error("mux in microprocessor mode");

  property p_whole_ports;
    (ext && whole) |-> (pin_roles_o.addr[15:9] == 7'h00) && (pin_roles_o.data == 16'h0000);
  endproperty
  a_whole_ports: assert property (p_whole_ports) else $error("upper pins kept in whole mux");

  property p_top_pins;
    (ext && !whole) |-> (pin_roles_o.addr[19:16] == {4{!cur.pm.top_port_io}});
  endproperty
  a_top_pins: assert property (p_top_pins) else $error("top address pins wrong role");

  property p_region;
    (ready_o && req_valid_i && ext && cur.pm.mux_sel == ebm_pkg::MUX_REG2) |=>
      (cur.mux == $past(req_i.region[1]));
  endproperty
  a_region: assert property (p_region) else $error("region two format wrong");

  property p_none;
    (ready_o && req_valid_i && cur.pm.mux_sel == ebm_pkg::MUX_NONE) |=> !cur.mux;
  endproperty
  a_none: assert property (p_none) else $error("mux with select 00");

  property p_width;
    (ext && !whole) |-> (pin_roles_o.data[15:8] == {8{w16}});
  endproperty
  a_width: assert property (p_width) else $error("data width mismatch");

  property p_single;
    !ext |-> (pin_roles_o == '0) && read_strobe_n_o && (addr_oe_o == 20'h0_0000);
  endproperty
  a_single: assert property (p_single) else $error("bus pins active in single-chip");

  property p_wait;
    (ready_o && req_valid_i && req_i.sw_wait) |=> s_waited_access;
  endproperty
  a_wait: assert property (p_wait) else $error("software wait not inserted");

  property p_write_strobe;
    (ext && cur.st == ebm_pkg::ST_DATA && cur.rq.we && cur.rq.be[0]) |->
      !low_byte_write_strobe_n_o && read_strobe_n_o;
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write strobe missing");

  // the external latch only sees a full address while the strobe is up
  property p_latch_addr;
    latch_strobe_port_pin_o |-> (addr_o == cur.rq.addr) && (addr_oe_o[8:0] == 9'h1ff);
  endproperty
  a_latch_addr: assert property (p_latch_addr) else $error("no address under strobe");

  // the far side drives the shared lines in a read, so we must let go
  property p_read_release;
    (cur.mux && cur.st == ebm_pkg::ST_DATA && !cur.rq.we) |->
      ((addr_oe_o & share) == 20'h0_0000) && !read_strobe_n_o;
  endproperty
  a_read_release: assert property (p_read_release) else $error("shared line driven");

  // separate writes drive the dedicated data pins at the selected width
  property p_sep_data;
    (ext && !whole && !cur.mux && cur.st == ebm_pkg::ST_DATA && cur.rq.we) |->
      (data_oe_o[7:0] == 8'hff) && (data_oe_o[15:8] == {8{w16}});
  endproperty
  a_sep_data: assert property (p_sep_data) else $error("data pins not driven");

  // split strobes: the high pin writes the upper byte, the low pin follows be[0]
  property p_split_strobe;
    (ext && cur.st == ebm_pkg::ST_DATA && cur.rq.we && sel16 && cur.rq.be[1]) |->
      !high_byte_write_strobe_n_o && (low_byte_write_strobe_n_o != cur.rq.be[0]);
  endproperty
  a_split_strobe: assert property (p_split_strobe) else $error("high strobe off");

  // bus clock runs at half the core rate once out of reset
  property p_bus_clock;
    !$past(reset_i) |-> (bus_clock_o != $past(bus_clock_o));
  endproperty
  a_bus_clock: assert property (p_bus_clock) else $error("bus clock stalled");

endmodule // ebm_ctrl
`default_nettype wire

/* test/ebm_mem_model.sv */
/*
  External byte memory on the far side of the bus controller.
  Assumes the controller's pin outputs are wired straight in, and that the
  bench tells it the bus width and whether the current access is multiplexed.
*/
`timescale 1ns/100ps
`default_nettype none
module ebm_mem_model (
  input  wire logic        clk_i,
  input  wire logic        word_i,
  input  wire logic        mux_i,
  input  wire logic        latch_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] data_i,
  output logic      [8:0]  shared_o,
  output logic      [15:0] data_o
);
  logic [7:0]  mem [0:255];  // one byte per slot
  logic [19:0] held_addr;    // address caught by the latch strobe
  logic [7:0]  slot;         // byte slot of this access
  logic [7:0]  last;         // last byte driven, inverted once released

  initial last = 8'h00;

  // external latch captures the address while the strobe is high
  always @(posedge clk_i) begin
    if (latch_i) held_addr <= addr_i;
  end

  // word-wide shared lines start at line one, so only even addresses reach us
  assign slot = !mux_i ? addr_i[7:0] : (word_i ? held_addr[8:1] : held_addr[7:0]);

  // write on the strobe, remember the read byte for the released level
  always @(posedge clk_i) begin
    if (!wr_n_i) mem[slot] <= !mux_i ? data_i[7:0] : (word_i ? addr_i[8:1] : addr_i[7:0]);
    if (!rd_n_i) last <= mem[slot];
  end

  // released lines show the inverse of the last value, never a stale copy
  always_comb begin
    shared_o = {~last[7], ~last};
    data_o   = {~last, ~last};
    if (!rd_n_i) begin
      if (mux_i && word_i) shared_o[8:1] = mem[slot];
      else if (mux_i) shared_o[7:0] = mem[slot];
      else data_o[7:0] = mem[slot];
    end
  end
endmodule  // ebm_mem_model
`default_nettype wire

/* test/testbench.sv */
/*
  Self-checking bench for the external bus controller: runs accesses in
  each mode and format and compares pin roles, timing and placement.
  Assumes the far-side memory model and a 50 ns core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                clk, rst, byte_pin, req_valid, ready, done, latch;
  logic                rd_n, wrl_n, wrh_n, bclk, mux, seen_mux, overlap, b0, wrh_seen;
  logic [1:0]          be_sel;
  ebm_pkg::ebm_pmode_t mode;
  ebm_pkg::ebm_req_t   req;
  ebm_pkg::ebm_roles_t roles;
  logic [15:0]         rdata, dat_o, dat_oe, dat_i, oe_wr;
  logic [19:0]         adr_o, adr_oe, a_ale, a_dat, oe_rd;
  logic [8:0]          adr_i;
  int                  n_fail, comparisons, lat;

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ebm_ctrl i_ebm_ctrl (.core_clk_i(clk), .reset_i(rst), .mode_ctrl_i(mode),
    .byte_pin_i(byte_pin), .req_valid_i(req_valid), .req_i(req), .ready_o(ready),
    .done_o(done), .rdata_o(rdata), .addr_o(adr_o), .addr_oe_o(adr_oe), .addr_i(adr_i),
    .data_o(dat_o), .data_oe_o(dat_oe), .data_i(dat_i), .latch_strobe_port_pin_o(latch),
    .read_strobe_n_o(rd_n), .low_byte_write_strobe_n_o(wrl_n),
    .high_byte_write_strobe_n_o(wrh_n), .bus_clock_o(bclk), .mux_cycle_o(mux),
    .pin_roles_o(roles));

  ebm_mem_model i_ebm_mem_model (.clk_i(clk), .word_i(~byte_pin), .mux_i(mux),
    .latch_i(latch), .rd_n_i(rd_n), .wr_n_i(wrl_n), .addr_i(adr_o), .data_i(dat_o),
    .shared_o(adr_i), .data_o(dat_i));

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // width pin only moves under reset, since it must stay fixed while running
  task automatic setm(input logic [1:0] m, input logic [1:0] sel, input logic top,
                      input logic bp);
    @(negedge clk);
    rst = 1'b1;
    byte_pin = bp;
    mode = '0;
    mode.mode = m;
    mode.mux_sel = sel;
    mode.top_port_io = top;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);  // mode register and width synchroniser settle
  endtask

  // one access; records latency, latched address and address pins in data phase
  task automatic run(input logic [19:0] a, input logic we, input logic [15:0] wd,
                     input logic [1:0] rg, input logic sw);
    @(negedge clk);
    req.addr = a;
    req.we = we;
    req.be = be_sel;
    req.wdata = wd;
    req.region = rg;
    req.sw_wait = sw;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    lat = 1;
    seen_mux = 1'b0;
    overlap = 1'b0;
    a_ale = '0;
    a_dat = '0;
    oe_rd = '0;
    oe_wr = '0;
    wrh_seen = 1'b0;
    while (done !== 1'b1 && lat < 20) begin
      if (latch === 1'b1) a_ale = adr_o;
      if (wrl_n === 1'b0) a_dat = adr_o;
      if (mux === 1'b1) seen_mux = 1'b1;
      if (latch !== 1'b0 && wrl_n !== 1'b1) overlap = 1'b1;
      if (rd_n === 1'b0) oe_rd = adr_oe;
      if (wrl_n === 1'b0 || wrh_n === 1'b0) oe_wr = dat_oe;
      if (wrh_n === 1'b0) wrh_seen = 1'b1;
      @(negedge clk);
      lat++;
    end
    chk(lat < 20, 1'b1);
  endtask

  initial begin
    rst = 1'b1;
    byte_pin = 1'b1;
    req_valid = 1'b0;
    req = '0;
    be_sel = 2'h1;
    mode = '0;
    n_fail = 0;
    comparisons = 0;
    a_ale = '0;
    a_dat = '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(ready, 1'b1);
    chk(done, 1'b0);
    chk(roles, '0);
    $display("test reset done");
    // separate bus, byte width
    setm(ebm_pkg::MODE_EXPAND, ebm_pkg::MUX_NONE, 1'b0, 1'b1);
    chk(roles.addr, 20'hf_ffff);
    chk(roles.data, 16'h00ff);
    chk(roles.ctrl, 1'b1);
    b0 = bclk;
    @(negedge clk);
    chk(bclk, !b0);
    run(20'h2_8034, 1'b1, 16'h005a, 2'h1, 1'b0);
    chk(lat, 4);
    chk(a_dat, 20'h2_8034);
    chk(seen_mux, 1'b0);
    chk(oe_wr, 16'h00ff);
    run(20'h2_8034, 1'b0, 16'h0000, 2'h1, 1'b0);
    chk(rdata, 16'h005a);
    chk(oe_rd, 20'hf_ffff);
    $display("test separate done");
    // whole space multiplexed, byte width, software wait on
    setm(ebm_pkg::MODE_EXPAND, ebm_pkg::MUX_ALL, 1'b0, 1'b1);
    chk(roles.addr, 20'h0_01ff);
    run(20'h2_8012, 1'b1, 16'h00a5, 2'h1, 1'b1);
    chk(lat, 5);
    chk(a_ale, 20'h2_8012);
    chk(overlap, 1'b0);
    chk(a_dat[7:0], 8'ha5);
    chk(seen_mux, 1'b1);
    run(20'h2_8012, 1'b0, 16'h0000, 2'h1, 1'b1);
    chk(rdata, 16'h00a5);
    chk(oe_rd, 20'h0_0100);
    $display("test whole space done");
    // one region multiplexed, the other separate
    for (int s = 1; s < 3; s++) begin
      setm(ebm_pkg::MODE_EXPAND, s[1:0], 1'b0, 1'b1);
      for (int r = 1; r < 3; r++) begin
        run(20'h2_8000, 1'b1, 16'h0011, r[1:0], 1'b1);
        chk(seen_mux, s == r);
      end
    end
    $display("test regions done");
    // word width, region one multiplexed, top pins left as ports
    setm(ebm_pkg::MODE_EXPAND, ebm_pkg::MUX_REG1, 1'b1, 1'b0);
    chk(roles.addr, 20'h0_ffff);
    chk(roles.data, 16'hffff);
    run(20'h2_8046, 1'b1, 16'h003c, 2'h1, 1'b1);
    chk(a_dat[8:1], 8'h3c);
    chk(a_ale, 20'h2_8046);
    chk(oe_wr, 16'hff00);
    run(20'h2_8046, 1'b0, 16'h0000, 2'h1, 1'b1);
    chk(rdata[7:0], 8'h3c);
    chk(oe_rd, 20'h0_fe01);
    // split byte strobes: an upper-byte write to the separate region
    mode.strobe_sel = 1'b1;
    be_sel = 2'h2;
    run(20'h2_8048, 1'b1, 16'h4400, 2'h2, 1'b1);
    chk(wrh_seen, 1'b1);
    chk(a_dat, 20'h0_0000);
    chk(oe_wr, 16'hffff);
    be_sel = 2'h1;
    $display("test word width done");
    // microprocessor mode cannot multiplex the whole space
    setm(ebm_pkg::MODE_MICRO, ebm_pkg::MUX_ALL, 1'b0, 1'b1);
    run(20'h3_0000, 1'b1, 16'h0022, 2'h0, 1'b1);
    chk(seen_mux, 1'b0);
    $display("test micro done");
    // single chip: no bus pins, software wait still counts
    setm(ebm_pkg::MODE_SINGLE, ebm_pkg::MUX_NONE, 1'b0, 1'b1);
    chk(roles, '0);
    run(20'h0_0400, 1'b1, 16'h0033, 2'h0, 1'b1);
    chk(lat, 5);
    run(20'h0_0400, 1'b1, 16'h0033, 2'h0, 1'b0);
    chk(lat, 4);
    $display("test single done");
    wrap_up();
  end

  // the whole run takes well under a thousand cycles
  initial begin
    #(3000 * 50);
    n_fail++;
    wrap_up();
  end
endmodule  // testbench
`default_nettype wire
